// File: src/pppf_top.v
// What this block does
// - fuse bits read 0 when programmed, 1 when unprogrammed.
// - high fuse: debug, scan, serial prog, osc option, preserve, boot size, vector.
// - high fuse defaults 1,0,0,1,1,0,0,1.
// - low fuse: brown-out level, brown-out enable, start-up 5:4, clock source 3:0.
// - low fuse defaults 1,1,1,0,0,0,0,1 (internal RC, 1MHz).
// - serial programming enable fuse cannot change through the serial path.
// - chip erase leaves every fuse bit unchanged.
// - fuse writes refused while the first lock bit is programmed.
// - live fuses captured at mode entry, act after exit; preserve fuse acts immediately.
// - three identification bytes readable at 0 to 2, even when locked.
// - four calibration bytes in signature high byte; 1MHz one loaded at reset.
// - flash has 256 pages of 64 words; word bits 5:0, page 13:6.
// - data EEPROM has 256 pages of 4 bytes; byte bits 1:0, page 9:2.
// - clock-pin rising edge: 00 address, 01 data, 10 command, 11 nothing.
// - write strobe runs command: 80 erase, 40 fuse write, 20 lock write.
// - command 10 writes flash, 11 writes data EEPROM.
// - commands 08 signature, 04 fuse and lock, 02 flash, 03 EEPROM reads.
// - ready/busy low from command acceptance until programming ends, high when idle and ready.
// - byte select a picks low/high; byte select b picks low/second high.
// - data bus driven from the clock after output enable goes low until the clock after it rises.
// - page-load pulse moves loaded data into the flash or EEPROM page buffer.
// - falling write strobe starts the operation; busy until it is done.
// - lock bits return to 1 only through chip erase or reset.
`timescale 1ns/1ps
`default_nettype none
`include "pppf_regs.vh"

module pppf_top #(
    parameter [7:0] SIG_BYTE0 = 8'h5a,  // arbitrary identity value
    parameter [7:0] SIG_BYTE1 = 8'h3c,  // arbitrary identity value
    parameter [7:0] SIG_BYTE2 = 8'h01,  // arbitrary identity value
    parameter [7:0] CAL_1MHZ  = 8'h80,
    parameter [7:0] CAL_2MHZ  = 8'h80,
    parameter [7:0] CAL_4MHZ  = 8'h80,
    parameter [7:0] CAL_8MHZ  = 8'h80,
    parameter       FLASH_AW  = `PPPF_FLASH_AW,
    parameter       NVDATA_AW = `PPPF_NVDATA_AW
) (
    // clock and reset
    input  wire       clk,
    input  wire       rst_n,
    input  wire       clkEn,
    // programming pins
    input  wire       progVoltageOk,
    input  wire       serialAccess,
    input  wire       loadStrobeClock,
    input  wire       actionSelHi,
    input  wire       actionSelLo,
    input  wire       byteSelectA,
    input  wire       byteSelectB,
    input  wire       pageBufferLoad,
    input  wire       writeStrobeN,
    input  wire       outputEnableN,
    // data bus, split three ways
    input  wire [7:0] dataIn,
    output reg  [7:0] dataOut,
    output reg        dataOutEn,
    // status
    output reg        readyBusyOut,
    // fuses in use by the rest of the chip
    output reg  [7:0] fuseConfigHighLive,
    output reg  [7:0] fuseConfigLowLive,
    output reg        keepNvdataOnErase,
    output reg  [7:0] rcTrimRegister
);

    localparam WS = `PPPF_FLASH_WORDSEL;
    localparam BS = `PPPF_NVDATA_BYTESEL;

    localparam [1:0] ST_IDLE   = 2'h0;
    localparam [1:0] ST_ERASE  = 2'h1;
    localparam [1:0] ST_PROG_F = 2'h2;
    localparam [1:0] ST_PROG_E = 2'h3;

    // ==========================================================
    // state
    reg [1:0]          state_reg;
    reg [7:0]          cmd_reg;
    reg [7:0]          addrLow_reg;
    reg [7:0]          addrHigh_reg;
    reg [7:0]          dataLow_reg;
    reg [7:0]          dataHigh_reg;
    reg [7:0]          fuseConfigHigh_reg;
    reg [7:0]          fuseConfigLow_reg;
    reg [7:0]          lock_reg;
    reg                progMode_reg;
    reg                strobePrev_reg;
    reg                pageLoadPrev_reg;
    reg                writePrev_reg;
    reg                voltPrev_reg;
    reg [FLASH_AW:0]   count_reg;
    reg                eraseNv_reg;

    wire [1:0] action = {actionSelHi, actionSelLo};
    wire strobeRise   = loadStrobeClock & ~strobePrev_reg;
    wire pageLoadRise = pageBufferLoad & ~pageLoadPrev_reg;
    wire writeFall    = ~writeStrobeN & writePrev_reg;
    wire idle         = (state_reg == ST_IDLE);

    wire [15:0]          addrFull = {addrHigh_reg, addrLow_reg};
    wire [FLASH_AW-1:0]  flashAddr = addrFull[FLASH_AW-1:0];
    wire [NVDATA_AW-1:0] nvAddr = addrFull[NVDATA_AW-1:0];

    // ==========================================================
    // command decode, used by the page buffer load enables
    function isCmd;
        input [7:0] cmd;
        input [7:0] code;
        begin
            isCmd = (cmd == code);
        end
    endfunction

    // ==========================================================
    // memories and page buffers
    wire [15:0] flashRd;
    wire [7:0]  nvRd;
    wire [15:0] fbufRd;
    wire [7:0]  ebufRd;

    reg                  flashWe;
    reg [FLASH_AW-1:0]   flashWa;
    reg [15:0]           flashWd;
    reg                  nvWe;
    reg [NVDATA_AW-1:0]  nvWa;
    reg [7:0]            nvWd;

    wire bufLoad = pageLoadRise & progMode_reg & idle;
    wire fbufWe  = bufLoad & isCmd(cmd_reg, `PPPF_CMD_WR_FLASH);
    wire ebufWe  = bufLoad & isCmd(cmd_reg, `PPPF_CMD_WR_NVDATA);

    wire [FLASH_AW:0] stepPrev = count_reg - {{FLASH_AW{1'b0}}, 1'b1};

    pppf_mem #(.DW(16), .AW(FLASH_AW)) flashMem (
        .clk    (clk),
        .clkEn  (clkEn),
        .wrEn   (flashWe),
        .wrAddr (flashWa),
        .wrData (flashWd),
        .rdAddr (flashAddr),
        .rdData (flashRd)
    );

    pppf_mem #(.DW(8), .AW(NVDATA_AW)) nvMem (
        .clk    (clk),
        .clkEn  (clkEn),
        .wrEn   (nvWe),
        .wrAddr (nvWa),
        .wrData (nvWd),
        .rdAddr (nvAddr),
        .rdData (nvRd)
    );

    // word-in-page from address bits 5:0
    pppf_mem #(.DW(16), .AW(WS)) flashPageBuf (
        .clk    (clk),
        .clkEn  (clkEn),
        .wrEn   (fbufWe),
        .wrAddr (addrLow_reg[WS-1:0]),
        .wrData ({dataHigh_reg, dataLow_reg}),
        .rdAddr (count_reg[WS-1:0]),
        .rdData (fbufRd)
    );

    // byte-in-page from address bits 1:0
    pppf_mem #(.DW(8), .AW(BS)) nvPageBuf (
        .clk    (clk),
        .clkEn  (clkEn),
        .wrEn   (ebufWe),
        .wrAddr (addrLow_reg[BS-1:0]),
        .wrData (dataLow_reg),
        .rdAddr (count_reg[BS-1:0]),
        .rdData (ebufRd)
    );

    // ==========================================================
    // memory write steering; buffer read lags one cycle
    always @*
    begin
        flashWe = 1'b0;
        flashWa = {FLASH_AW{1'b0}};
        flashWd = `PPPF_ERASED_WORD;
        nvWe    = 1'b0;
        nvWa    = {NVDATA_AW{1'b0}};
        nvWd    = `PPPF_ERASED_BYTE;
        case (state_reg)
            ST_ERASE:
            begin
                flashWe = ~count_reg[FLASH_AW];
                flashWa = count_reg[FLASH_AW-1:0];
                nvWe    = eraseNv_reg & (count_reg < (1 << NVDATA_AW));
                nvWa    = count_reg[NVDATA_AW-1:0];
            end
            ST_PROG_F:
            begin
                // page from bits 13:6, word from the counter
                flashWe = (count_reg != 0);
                flashWa = {flashAddr[FLASH_AW-1:WS], stepPrev[WS-1:0]};
                flashWd = fbufRd;
            end
            ST_PROG_E:
            begin
                nvWe = (count_reg != 0);
                nvWa = {nvAddr[NVDATA_AW-1:BS], stepPrev[BS-1:0]};
                nvWd = ebufRd;
            end
            default:
            begin
                flashWe = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // strobes, latches and the operation sequencer
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg          <= ST_IDLE;
            cmd_reg            <= `PPPF_CMD_NOP;
            addrLow_reg        <= 8'h00;
            addrHigh_reg       <= 8'h00;
            dataLow_reg        <= 8'h00;
            dataHigh_reg       <= 8'h00;
            fuseConfigHigh_reg <= `PPPF_FUSE_HIGH_RST;
            fuseConfigLow_reg  <= `PPPF_FUSE_LOW_RST;
            lock_reg           <= `PPPF_LOCK_RST;
            progMode_reg       <= 1'b0;
            strobePrev_reg     <= 1'b0;
            pageLoadPrev_reg   <= 1'b0;
            writePrev_reg      <= 1'b1;
            voltPrev_reg       <= 1'b0;
            count_reg          <= {(FLASH_AW+1){1'b0}};
            eraseNv_reg        <= 1'b0;
        end
        else if (clkEn)
        begin
            strobePrev_reg   <= loadStrobeClock;
            pageLoadPrev_reg <= pageBufferLoad;
            writePrev_reg    <= writeStrobeN;
            voltPrev_reg     <= progVoltageOk;
            // entry needs the four-pin pattern at zero as voltage arrives
            if (progVoltageOk & ~voltPrev_reg & ~pageBufferLoad & ~actionSelHi
                & ~actionSelLo & ~byteSelectA)
                progMode_reg <= 1'b1;
            else if (~progVoltageOk)
                progMode_reg <= 1'b0;

            // latches hold until the next matching load
            if (progMode_reg & idle & strobeRise)
            begin
                case (action)
                    `PPPF_ACT_ADDR:
                    begin
                        if (byteSelectA)
                            addrHigh_reg <= dataIn;
                        else
                            addrLow_reg <= dataIn;
                    end
                    `PPPF_ACT_DATA:
                    begin
                        if (byteSelectA)
                            dataHigh_reg <= dataIn;
                        else
                            dataLow_reg <= dataIn;
                    end
                    `PPPF_ACT_CMD:
                        cmd_reg <= dataIn;
                    default:
                        cmd_reg <= cmd_reg;
                endcase
            end

            case (state_reg)
                ST_IDLE:
                begin
                    count_reg <= {(FLASH_AW+1){1'b0}};
                    if (progMode_reg & writeFall)
                    begin
                        case (cmd_reg)
                            `PPPF_CMD_ERASE:
                            begin
                                state_reg   <= ST_ERASE;
                                // preserve fuse is honoured at once, not latched
                                eraseNv_reg <= fuseConfigHigh_reg[`PPPF_FH_KEEP_NVDATA];
                            end
                            `PPPF_CMD_WR_FUSE:
                            begin
                                // locked fuses silently ignore the write
                                if (lock_reg[`PPPF_LOCK_FIRST])
                                begin
                                    if (byteSelectA)
                                        fuseConfigHigh_reg <= serialAccess ?
                                            {dataLow_reg[7:6],
                                             fuseConfigHigh_reg[`PPPF_FH_SERIAL_PROG],
                                             dataLow_reg[4:0]} :
                                            dataLow_reg;
                                    else if (!byteSelectB)
                                        fuseConfigLow_reg <= dataLow_reg;
                                end
                            end
                            `PPPF_CMD_WR_LOCK:
                                lock_reg <= lock_reg & dataLow_reg;
                            `PPPF_CMD_WR_FLASH:
                                state_reg <= ST_PROG_F;
                            `PPPF_CMD_WR_NVDATA:
                                state_reg <= ST_PROG_E;
                            default:
                                state_reg <= ST_IDLE;
                        endcase
                    end
                end
                ST_ERASE:
                begin
                    // fuses are left alone; lock bits clear only at the end
                    count_reg <= count_reg + {{FLASH_AW{1'b0}}, 1'b1};
                    if (count_reg[FLASH_AW])
                    begin
                        lock_reg  <= `PPPF_LOCK_RST;
                        state_reg <= ST_IDLE;
                    end
                end
                ST_PROG_F:
                begin
                    count_reg <= count_reg + {{FLASH_AW{1'b0}}, 1'b1};
                    if (count_reg == (1 << WS))
                        state_reg <= ST_IDLE;
                end
                ST_PROG_E:
                begin
                    count_reg <= count_reg + {{FLASH_AW{1'b0}}, 1'b1};
                    if (count_reg == (1 << BS))
                        state_reg <= ST_IDLE;
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // read data selection
    reg [7:0] readByte;

    always @*
    begin
        readByte = 8'hff;
        case (cmd_reg)
            `PPPF_CMD_RD_SIG:
            begin
                // not gated by lock bits
                if (byteSelectA)
                begin
                    case (addrLow_reg[1:0])
                        2'h0:    readByte = CAL_1MHZ;
                        2'h1:    readByte = CAL_2MHZ;
                        2'h2:    readByte = CAL_4MHZ;
                        default: readByte = CAL_8MHZ;
                    endcase
                end
                else
                begin
                    case (addrLow_reg[1:0])
                        2'h0:    readByte = SIG_BYTE0;
                        2'h1:    readByte = SIG_BYTE1;
                        2'h2:    readByte = SIG_BYTE2;
                        default: readByte = 8'hff;
                    endcase
                end
            end
            `PPPF_CMD_RD_FUSE:
            begin
                // stored value as is: programmed bits read 0
                case ({byteSelectB, byteSelectA})
                    2'h0:    readByte = fuseConfigLow_reg;
                    2'h3:    readByte = fuseConfigHigh_reg;
                    2'h1:    readByte = lock_reg;
                    default: readByte = 8'hff;
                endcase
            end
            `PPPF_CMD_RD_FLASH:
                readByte = byteSelectA ? flashRd[15:8] : flashRd[7:0];
            `PPPF_CMD_RD_NVDATA:
                readByte = nvRd;
            default:
                readByte = 8'hff;
        endcase
    end

    // ==========================================================
    // pins and live fuse copies
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dataOut            <= 8'h00;
            dataOutEn          <= 1'b0;
            readyBusyOut       <= 1'b1;
            fuseConfigHighLive <= `PPPF_FUSE_HIGH_RST;
            fuseConfigLowLive  <= `PPPF_FUSE_LOW_RST;
            keepNvdataOnErase  <= 1'b1;
            rcTrimRegister     <= CAL_1MHZ;
        end
        else if (clkEn)
        begin
            dataOut <= readByte;
            // registered enable drops one clock after the pin rises
            dataOutEn    <= progMode_reg & ~outputEnableN;
            readyBusyOut <= idle & ~(progMode_reg & writeFall);
            // copy only outside programming mode: frozen at entry, new after exit
            if (!progMode_reg)
            begin
                fuseConfigHighLive <= fuseConfigHigh_reg;
                fuseConfigLowLive  <= fuseConfigLow_reg;
            end
            keepNvdataOnErase <= fuseConfigHigh_reg[`PPPF_FH_KEEP_NVDATA];
        end
    end

endmodule // pppf_top

`default_nettype wire

// File: src/pppf_regs.vh
`ifndef PPPF_REGS_VH
`define PPPF_REGS_VH

// ==========================================================
// command bytes
`define PPPF_CMD_NOP        8'h00
`define PPPF_CMD_ERASE      8'h80
`define PPPF_CMD_WR_FUSE    8'h40
`define PPPF_CMD_WR_LOCK    8'h20
`define PPPF_CMD_WR_FLASH   8'h10
`define PPPF_CMD_WR_NVDATA  8'h11
`define PPPF_CMD_RD_SIG     8'h08
`define PPPF_CMD_RD_FUSE    8'h04
`define PPPF_CMD_RD_FLASH   8'h02
`define PPPF_CMD_RD_NVDATA  8'h03

// ==========================================================
// action select codes
`define PPPF_ACT_ADDR       2'h0
`define PPPF_ACT_DATA       2'h1
`define PPPF_ACT_CMD        2'h2
`define PPPF_ACT_IDLE       2'h3

// ==========================================================
// high fuse byte fields
`define PPPF_FH_ONCHIP_DEBUG  7
`define PPPF_FH_SCAN_PORT     6
`define PPPF_FH_SERIAL_PROG   5
`define PPPF_FH_OSC_OPTION    4
`define PPPF_FH_KEEP_NVDATA   3
`define PPPF_FH_BOOT_SIZE_HI  2
`define PPPF_FH_BOOT_SIZE_LO  1
`define PPPF_FH_RESET_VECTOR  0

// ==========================================================
// low fuse byte fields
`define PPPF_FL_BROWNOUT_LVL  7
`define PPPF_FL_BROWNOUT_ON   6
`define PPPF_FL_STARTUP_HI    5
`define PPPF_FL_STARTUP_LO    4
`define PPPF_FL_CLKSRC_HI     3
`define PPPF_FL_CLKSRC_LO     0

// ==========================================================
// reset values, 0 = programmed
`define PPPF_FUSE_HIGH_RST  8'h99
`define PPPF_FUSE_LOW_RST   8'he1
`define PPPF_LOCK_RST       8'hff
`define PPPF_ERASED_BYTE    8'hff
`define PPPF_ERASED_WORD    16'hffff
`define PPPF_LOCK_FIRST     0

// ==========================================================
// geometry
`define PPPF_FLASH_AW       14
`define PPPF_FLASH_WORDSEL  6
`define PPPF_NVDATA_AW      10
`define PPPF_NVDATA_BYTESEL 2

`endif

// File: src/pppf_mem.v
`timescale 1ns/1ps
`default_nettype none

module pppf_mem #(
    parameter DW = 8,
    parameter AW = 4
) (
    // clock
    input  wire          clk,
    input  wire          clkEn,
    // write port
    input  wire          wrEn,
    input  wire [AW-1:0] wrAddr,
    input  wire [DW-1:0] wrData,
    // read port, registered
    input  wire [AW-1:0] rdAddr,
    output reg  [DW-1:0] rdData
);

    reg [DW-1:0] store [0:(1<<AW)-1];

    // ==========================================================
    // no reset on the array: contents are nonvolatile by intent
    always @(posedge clk)
    begin
        if (clkEn)
        begin
            if (wrEn)
                store[wrAddr] <= wrData;
            rdData <= store[rdAddr];
        end
    end

endmodule // pppf_mem

`default_nettype wire

// File: verification/pppf_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// port checker
module pppf_chk #(
    parameter [7:0] CAL1 = 8'h80
) (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // pins
    input wire logic       progVoltageOk,
    input wire logic       writeStrobeN,
    input wire logic       outputEnableN,
    input wire logic       dataOutEn,
    input wire logic       readyBusyOut,
    // fuses in use
    input wire logic [7:0] fuseConfigHighLive,
    input wire logic [7:0] fuseConfigLowLive,
    input wire logic [7:0] rcTrimRegister
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_high_fuse_rst:
        assert property ($rose(rst_n) |-> fuseConfigHighLive == 8'h99) else $error("high fuse");
    a_low_fuse_rst:
        assert property ($rose(rst_n) |-> fuseConfigLowLive == 8'he1) else $error("low fuse");
    a_trim_rst:
        assert property ($rose(rst_n) |-> rcTrimRegister == CAL1) else $error("trim reset");
    a_trim_hold:
        assert property ($stable(rcTrimRegister)) else $error("trim moved");
    a_bus_release:
        assert property (outputEnableN |=> !dataOutEn) else $error("bus not released");
    a_drive_cause:
        assert property (dataOutEn |-> !$past(outputEnableN)) else $error("bus driven");
    a_oe_drive:
        assert property (progVoltageOk && $past(progVoltageOk, 2) && !outputEnableN |=> dataOutEn)
        else $error("bus not driven");
    a_busy_cause:
        assert property ($fell(readyBusyOut) |-> !$past(writeStrobeN)) else $error("busy");
    a_live_hold:
        assert property (progVoltageOk && $past(progVoltageOk) |->
            $stable(fuseConfigHighLive) && $stable(fuseConfigLowLive)) else $error("live fuse");
endmodule // pppf_chk
`default_nettype wire

// File: verification/pppf_prog_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// programmer model, pins change on the falling edge
module pppf_prog_model (
    // status in
    input  wire logic       clk,
    input  wire logic       readyBusyOut,
    // pins out
    output logic            progVoltageOk,
    output logic            loadStrobeClock,
    output logic [1:0]      act,
    output logic            bsA,
    output logic            bsB,
    output logic            pageBufferLoad,
    output logic            writeStrobeN,
    output logic            outputEnableN,
    output logic [7:0]      dataIn
);
    initial
    begin
        {progVoltageOk, loadStrobeClock, act, bsA, bsB, pageBufferLoad} = 7'h18;
        {writeStrobeN, outputEnableN, dataIn} = 10'h300;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic enter;
        {pageBufferLoad, act, bsA} = 4'h0;
        tick(2);
        progVoltageOk = 1'b1;
        tick(2);
    endtask
    task automatic ld(input logic [1:0] a, input logic s, input logic [7:0] d);
        act = a;
        bsA = s;
        dataIn = d;
        tick(2);
        loadStrobeClock = 1'b1;
        tick(2);
        loadStrobeClock = 1'b0;
        act = 2'h3;
        tick(2);
    endtask
    task automatic pl;
        pageBufferLoad = 1'b1;
        tick(2);
        pageBufferLoad = 1'b0;
        tick(2);
    endtask
    task automatic wr(input logic s, output logic ok);
        int i;
        bsA = s;
        tick(2);
        writeStrobeN = 1'b0;
        tick(2);
        writeStrobeN = 1'b1;
        // bounded: erase is the longest wait
        for (i = 0; i < 20000 && readyBusyOut !== 1'b1; i++)
            tick(1);
        ok = (readyBusyOut === 1'b1);
        tick(2);
    endtask
    task automatic rd(input logic s, input logic b);
        bsA = s;
        bsB = b;
        tick(2);
        outputEnableN = 1'b0;
        dataIn = ~dataIn; // stale bus value must not leak into a read
        tick(4);
    endtask
endmodule // pppf_prog_model
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// bench top
module tb;
    localparam [23:0] SIG  = 24'h013c5a; // arbitrary identity values
    localparam [7:0]  CAL1 = 8'h80;
    logic        clk, rst_n, serialAccess, pv, lsc, bA, bB, pbl, wrN, oeN, doe, rdy, keep, ok;
    logic [1:0]  act;
    logic [7:0]  din, dout, fh, fl, trim, v, h, e;
    logic [15:0] a, d;
    logic [7:0]  expQ[$];
    int          errCount = 0;
    int          testsRun = 0;
    event        take;
    pppf_top #(.SIG_BYTE0(SIG[7:0]), .SIG_BYTE1(SIG[15:8]), .SIG_BYTE2(SIG[23:16]),
        .CAL_1MHZ(CAL1)) dut (.clk(clk), .rst_n(rst_n), .clkEn(1'b1), .progVoltageOk(pv),
        .serialAccess(serialAccess), .loadStrobeClock(lsc), .actionSelHi(act[1]),
        .actionSelLo(act[0]), .byteSelectA(bA), .byteSelectB(bB), .pageBufferLoad(pbl),
        .writeStrobeN(wrN), .outputEnableN(oeN), .dataIn(din), .dataOut(dout),
        .dataOutEn(doe), .readyBusyOut(rdy), .fuseConfigHighLive(fh),
        .fuseConfigLowLive(fl), .keepNvdataOnErase(keep), .rcTrimRegister(trim));
    pppf_prog_model p (.clk(clk), .readyBusyOut(rdy), .progVoltageOk(pv),
        .loadStrobeClock(lsc), .act(act), .bsA(bA), .bsB(bB), .pageBufferLoad(pbl),
        .writeStrobeN(wrN), .outputEnableN(oeN), .dataIn(din));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        testsRun++;
        if (got !== exp)
        begin
            errCount++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic endSim;
        $display("checks %0d errors %0d", testsRun, errCount);
        if (errCount == 0 && testsRun > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // results are compared only when the bus is settled
    always @(take) chk(doe ? dout : 8'hxx, expQ.pop_front());
    task automatic rdq(input logic s, input logic b, input logic [7:0] x);
        expQ.push_back(x);
        p.rd(s, b);
        ->take;
        p.outputEnableN = 1'b1;
        p.tick(2);
    endtask
    task automatic w(input logic s);
        p.wr(s, ok);
        if (!ok)
        begin
            errCount++;
            endSim();
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        p.ld(2'h2, 1'b0, c);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial
    begin
        {rst_n, serialAccess} = 2'b00;
        void'($urandom(34086));
        {v, h, e, a, d} = 56'({$urandom, $urandom});
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        chk(fh, 8'h99);
        chk(fl, 8'he1);
        chk(trim, CAL1);
        chk({7'h0, rdy}, 8'h01);
        p.enter();
        cmd(8'h04);
        p.ld(2'h3, 1'b0, 8'h80);
        rdq(0, 0, 8'he1);
        rdq(1, 1, 8'h99);
        rdq(1, 0, 8'hff);
        cmd(8'h08);
        for (int i = 0; i < 3; i++)
        begin
            p.ld(2'h0, 1'b0, 8'(i));
            rdq(0, 0, SIG[8*i +: 8]);
        end
        p.ld(2'h0, 1'b0, 8'h00);
        rdq(1, 0, CAL1);
        cmd(8'h40);
        p.ld(2'h1, 1'b0, v);
        w(0);
        p.ld(2'h1, 1'b0, h);
        w(1);
        chk(fh, 8'h99);
        chk({7'h0, keep}, {7'h0, h[3]});
        serialAccess = 1'b1;
        p.ld(2'h1, 1'b0, h ^ 8'h20);
        w(1);
        serialAccess = 1'b0;
        cmd(8'h04);
        rdq(0, 0, v);
        rdq(1, 1, h);
        a[15:14] = 2'h0;
        cmd(8'h10);
        p.ld(2'h0, 1'b0, a[7:0]);
        p.ld(2'h1, 1'b0, d[7:0]);
        p.ld(2'h1, 1'b1, d[15:8]);
        p.pl();
        p.ld(2'h0, 1'b1, a[15:8]);
        w(0);
        cmd(8'h02);
        rdq(0, 0, d[7:0]);
        rdq(1, 0, d[15:8]);
        cmd(8'h11);
        p.ld(2'h0, 1'b1, a[15:8] & 8'h03);
        p.ld(2'h1, 1'b0, e);
        p.pl();
        w(0);
        cmd(8'h03);
        rdq(0, 0, e);
        cmd(8'h20);
        p.ld(2'h1, 1'b0, 8'hfe);
        w(0);
        cmd(8'h40);
        p.ld(2'h1, 1'b0, ~v);
        w(0);
        cmd(8'h04);
        rdq(0, 0, v);
        rdq(1, 0, 8'hfe);
        cmd(8'h80);
        w(0);
        cmd(8'h04);
        rdq(0, 0, v);
        rdq(1, 0, 8'hff);
        cmd(8'h02);
        rdq(0, 0, 8'hff);
        cmd(8'h03);
        rdq(0, 0, h[3] ? 8'hff : e);
        p.progVoltageOk = 1'b0;
        p.tick(4);
        chk(fl, v);
        chk(fh, h);
        endSim();
    end
endmodule // tb
bind pppf_top pppf_chk #(.CAL1(CAL_1MHZ)) chk_i (.clk(clk), .rst_n(rst_n),
    .progVoltageOk(progVoltageOk), .writeStrobeN(writeStrobeN),
    .outputEnableN(outputEnableN), .dataOutEn(dataOutEn), .readyBusyOut(readyBusyOut),
    .fuseConfigHighLive(fuseConfigHighLive), .fuseConfigLowLive(fuseConfigLowLive),
    .rcTrimRegister(rcTrimRegister));
`default_nettype wire
